// ### verilog/gsp_pkg.sv
// Shared constants for the gauge subcommand and status port
package gsp_pkg;
	// Byte locations of the register pairs
	localparam logic [7:0] GSP_ADDR_CMD_LO = 8'h00;
	localparam logic [7:0] GSP_ADDR_CMD_HI = 8'h01;
	localparam logic [7:0] GSP_ADDR_RATE_LO = 8'h02;
	localparam logic [7:0] GSP_ADDR_RATE_HI = 8'h03;
	localparam logic [7:0] GSP_ADDR_TTE_LO = 8'h04;
	localparam logic [7:0] GSP_ADDR_TTE_HI = 8'h05;
	localparam logic [7:0] GSP_ADDR_TEMP_LO = 8'h06;
	localparam logic [7:0] GSP_ADDR_TEMP_HI = 8'h07;
	localparam logic [7:0] GSP_ADDR_VOLT_LO = 8'h08;
	localparam logic [7:0] GSP_ADDR_VOLT_HI = 8'h09;
	localparam logic [7:0] GSP_ADDR_FLAG_LO = 8'h0a;
	localparam logic [7:0] GSP_ADDR_FLAG_HI = 8'h0b;

	// Subcommand codes
	localparam logic [15:0] GSP_CMD_OTG_ON = 16'h0015;
	localparam logic [15:0] GSP_CMD_OTG_OFF = 16'h0016;
	localparam logic [15:0] GSP_CMD_HALF_ON = 16'h0017;
	localparam logic [15:0] GSP_CMD_PROF_ZERO = 16'h0018;
	localparam logic [15:0] GSP_CMD_PROF_ONE = 16'h0019;
	localparam logic [15:0] GSP_CMD_CHG_RELEASE = 16'h001a;
	localparam logic [15:0] GSP_CMD_CHG_BLOCK = 16'h001b;
	localparam logic [15:0] GSP_CMD_HOST_GRANT = 16'h001c;
	localparam logic [15:0] GSP_CMD_HOST_REVOKE = 16'h001d;
	localparam logic [15:0] GSP_CMD_HALF_OFF = 16'h001e;
	localparam logic [15:0] GSP_CMD_CFG_REV = 16'h001f;
	localparam logic [15:0] GSP_CMD_SEAL = 16'h0020;
	localparam logic [15:0] GSP_CMD_GAUGE_START = 16'h0021;
	localparam logic [15:0] GSP_CMD_FULL_RESET = 16'h0041;
	localparam logic [15:0] GSP_CMD_SHIP_ON = 16'h0050;
	localparam logic [15:0] GSP_CMD_SHIP_OFF = 16'h0051;

	// Reset values and fixed figures
	localparam logic [15:0] GSP_RATE_RESET = 16'h0000;
	localparam logic [15:0] GSP_TEMP_RESET = 16'h0000;
	localparam logic [15:0] GSP_TTE_IDLE = 16'hffff;
	localparam logic [15:0] GSP_TTE_MAX = 16'hfffe;
	localparam logic [15:0] GSP_VOLT_MAX_MV = 16'h1770;
	localparam logic [7:0] GSP_GAUGE_ENABLE_VAL = 8'h01;
	localparam logic [15:0] GSP_MIN_PER_HOUR = 16'h003c;

	// Flag word bit positions
	localparam int GSP_FLAG_OVER_TEMP = 15;
	localparam int GSP_FLAG_UNDER_TEMP = 14;
	localparam int GSP_FLAG_CALIB = 12;
	localparam int GSP_FLAG_HALF_CUR = 11;
	localparam int GSP_FLAG_HOST_CTRL = 10;
	localparam int GSP_FLAG_FULL_CHG = 9;
	localparam int GSP_FLAG_CHARGING = 8;
	localparam int GSP_FLAG_GOOD_OCV = 5;
	localparam int GSP_FLAG_AWAIT_ID = 4;
	localparam int GSP_FLAG_BATT_DET = 3;
	localparam int GSP_FLAG_SOC_ONE = 2;
	localparam int GSP_FLAG_SYS_DOWN = 1;
	localparam int GSP_FLAG_DISCHG = 0;

	// Recompute period and its cycle count
	localparam int unsigned GSP_CLK_HZ = 250000000;
	localparam int unsigned GSP_REFRESH_S = 1;
	localparam int unsigned GSP_REFRESH_CYCLES = GSP_CLK_HZ * GSP_REFRESH_S;

	typedef enum logic [2:0] {
		GSP_DIV_IDLE = 3'b001,
		GSP_DIV_RUN = 3'b010,
		GSP_DIV_DONE = 3'b100
	} gsp_div_state_t;
endpackage

// ### verilog/gsp_fct_if.sv
// Link between the port logic and the forecast calculator
`timescale 1ns/1ps
interface gsp_fct_if;
	logic start;
	logic [15:0] rate;
	logic [15:0] capacity;
	logic [15:0] timeToEmpty;
	logic busy;
	modport port (output start, output rate, output capacity, input timeToEmpty, input busy);
	modport calc (input start, input rate, input capacity, output timeToEmpty, output busy);
endinterface

// ### verilog/gsp_forecast_calc.sv
// Forecast time-to-empty calculator, serial restoring divider
`timescale 1ns/1ps
module gsp_forecast_calc (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Port side
	gsp_fct_if.calc fct
);
	import gsp_pkg::*;

	gsp_div_state_t state_q;
	logic [31:0] dividend_q;
	logic [15:0] divisor_q;
	logic [16:0] remain_q;
	logic [31:0] quot_q;
	logic [5:0] step_q;
	logic [15:0] tte_q;
	wire logic [16:0] trialRem;
	wire logic trialOk;
	wire logic [15:0] magnitude;
	wire logic discharging;
	wire logic [31:0] charge;

	assign discharging = fct.rate[15];
	assign magnitude = 16'(-fct.rate);
	assign charge = 32'(fct.capacity) * 32'(GSP_MIN_PER_HOUR);
	assign trialRem = {remain_q[15:0], dividend_q[31]};
	assign trialOk = trialRem >= {1'b0, divisor_q};
	assign fct.timeToEmpty = tte_q;
	assign fct.busy = state_q != GSP_DIV_IDLE;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= GSP_DIV_IDLE;
			dividend_q <= 32'h0;
			divisor_q <= 16'h0;
			remain_q <= 17'h0;
			quot_q <= 32'h0;
			step_q <= 6'h0;
			tte_q <= GSP_TTE_IDLE;
		end else begin
			unique case (state_q)
				GSP_DIV_IDLE: begin
					if (fct.start && !discharging) begin
						// Zero or charging rate has no time-to-empty
						tte_q <= GSP_TTE_IDLE;
					end else if (fct.start) begin
						dividend_q <= charge;
						divisor_q <= magnitude;
						remain_q <= 17'h0;
						quot_q <= 32'h0;
						step_q <= 6'h0;
						state_q <= GSP_DIV_RUN;
					end
				end
				GSP_DIV_RUN: begin
					remain_q <= trialOk ? 17'(trialRem - {1'b0, divisor_q}) : trialRem;
					quot_q <= {quot_q[30:0], trialOk};
					dividend_q <= {dividend_q[30:0], 1'b0};
					step_q <= 6'(step_q + 6'h1);
					if (step_q == 6'h1f) begin
						state_q <= GSP_DIV_DONE;
					end
				end
				GSP_DIV_DONE: begin
					// Clamp keeps the idle code reserved for a zero or charging rate
					tte_q <= (quot_q > 32'(GSP_TTE_MAX)) ? GSP_TTE_MAX : quot_q[15:0];
					state_q <= GSP_DIV_IDLE;
				end
			endcase
		end
	end
endmodule

// ### verilog/gsp_port.sv
// Gauge subcommand decoder, charger control and status word port
// Behaviour
// - Host writes 16-bit subcommand at 0x00/0x01; results read back there.
// - 0x0015 turns charger OTG mode on, 0x0016 turns it off.
// - 0x0017 halves programmed charge current, 0x001E restores full current.
// - 0x0018 clears profile select; removal sequence if it was one.
// - 0x0019 sets profile select; removal sequence if it was zero.
// - 0x001B forces charger active-low enable high, blocking charge.
// - 0x001A releases the forced high; algorithm drives enable again.
// - 0x001C grants host-mode charger control only if command-not-required clear.
// - 0x001D revokes host-mode control only if command-not-required clear.
// - 0x001F returns the stored 16-bit configuration revision, default zero.
// - 0x0020 moves access state from unsealed to sealed.
// - 0x0021 while unsealed starts gauging, enable 0x01, sets voltage-ok and update.
// - 0x0041 while unsealed performs a full reset of the device.
// - 0x0050 turns battery switch off after the configured delay.
// - 0x0051 cancels pending switch-off, or turns it on with VBUS present.
// - Forecast rate at 0x02/0x03 is signed mA, read-write, resets zero.
// - Time-to-empty is 0 to 65534 minutes, 65535 when rate is zero or positive.
// - Time-to-empty refreshes within one second of a write, then every second.
// - Temperature word in 0.1 K; with write option, writes stick and read back.
// - Both options zero: temperature read returns the internal sensor.
// - Voltage word at 0x08/0x09 is read-only millivolts, 0 to 6000.
// - Status flag word at 0x0A carries the listed status bits.
// - Under- and over-temperature flags follow the detected conditions.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module gsp_port
	import gsp_pkg::*;
#(
	parameter int unsigned REFRESH_CYCLES = gsp_pkg::GSP_REFRESH_CYCLES,
	parameter int DELAY_W = 16
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrStrobe,
	input wire logic regRdStrobe,
	output logic [7:0] regRdData,
	// Configuration from nonvolatile storage, same clock
	input wire logic cmdNotRequired,
	input wire logic writeTemperatureOption,
	input wire logic sensorSelectOption,
	input wire logic [15:0] configRevision,
	input wire logic [DELAY_W-1:0] shipDelaySeconds,
	// Pin-level status from outside the clock domain
	input wire logic vbusPresent,
	input wire logic overTempCond,
	input wire logic underTempCond,
	input wire logic calibrationActive,
	input wire logic fullCharge,
	input wire logic goodRestVoltage,
	input wire logic awaitingPackId,
	input wire logic batteryDetected,
	input wire logic chargeThresholdOne,
	input wire logic systemShutdown,
	input wire logic dischargingCond,
	input wire logic voltagesUnsuitable,
	input wire logic algoChargeEnableN,
	input wire logic [15:0] measuredVoltage,
	input wire logic [15:0] internalTemp,
	input wire logic [15:0] externalTemp,
	input wire logic [15:0] remainingCapacity,
	// Charger control
	output logic otgEnable,
	output logic chargeEnableN,
	output logic halfCurrent,
	output logic hostControl,
	output logic batteryPowerSwitchOn,
	// Gauge state
	output logic packProfileSelect,
	output logic packRemovalPulse,
	output logic gaugingStartPulse,
	output logic [7:0] gaugingEnable,
	output logic voltageOkFlag,
	output logic capacityUpdateEnable,
	output logic sealed,
	output logic fullResetPulse
);
	import gsp_pkg::*;

	localparam int SYNC_W = 13 + 64;

	// Two-stage synchroniser for everything that arrives from pins
	logic [SYNC_W-1:0] syncA_q;
	logic [SYNC_W-1:0] syncB_q;
	wire logic [SYNC_W-1:0] pinBundle;
	wire logic sVbus;
	wire logic sOverTemp;
	wire logic sUnderTemp;
	wire logic sCalib;
	wire logic sFullChg;
	wire logic sGoodOcv;
	wire logic sAwaitId;
	wire logic sBattDet;
	wire logic sSocOne;
	wire logic sSysDown;
	wire logic sDischg;
	wire logic sVoltsBad;
	wire logic sAlgoCeN;
	wire logic [15:0] sVoltage;
	wire logic [15:0] sIntTemp;
	wire logic [15:0] sExtTemp;
	wire logic [15:0] sCapacity;

	assign pinBundle = {vbusPresent, overTempCond, underTempCond, calibrationActive, fullCharge,
		goodRestVoltage, awaitingPackId, batteryDetected, chargeThresholdOne, systemShutdown,
		dischargingCond, voltagesUnsuitable, algoChargeEnableN, measuredVoltage, internalTemp,
		externalTemp, remainingCapacity};
	assign {sVbus, sOverTemp, sUnderTemp, sCalib, sFullChg, sGoodOcv, sAwaitId, sBattDet,
		sSocOne, sSysDown, sDischg, sVoltsBad, sAlgoCeN, sVoltage, sIntTemp, sExtTemp,
		sCapacity} = syncB_q;

	// Multi-bit values are slow analogue readings; a torn sample lasts one cycle only
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			syncA_q <= '0;
			syncB_q <= '0;
		end else begin
			syncA_q <= pinBundle;
			syncB_q <= syncA_q;
		end
	end

	// Register state
	logic [15:0] cmdWord_q;
	logic [7:0] rateLo_q;
	logic [15:0] rate_q;
	logic [7:0] tempLo_q;
	logic [15:0] temp_q;
	logic otg_q;
	logic blockChg_q;
	logic half_q;
	logic host_q;
	logic prof_q;
	logic removal_q;
	logic gstart_q;
	logic [7:0] genable_q;
	logic vok_q;
	logic qen_q;
	logic sealed_q;
	logic fullReset_q;
	logic shipPending_q;
	logic switchOn_q;
	logic [DELAY_W-1:0] shipCount_q;
	logic execute_q;
	logic rateCommit_q;
	logic [7:0] rdData_q;
	logic [31:0] tickCount_q;
	logic tick_q;

	// Address decode
	wire logic wrCmdLo;
	wire logic wrCmdHi;
	wire logic wrRateLo;
	wire logic wrRateHi;
	wire logic wrTempLo;
	wire logic wrTempHi;
	assign wrCmdLo = regWrStrobe && regAddr == GSP_ADDR_CMD_LO;
	assign wrCmdHi = regWrStrobe && regAddr == GSP_ADDR_CMD_HI;
	assign wrRateLo = regWrStrobe && regAddr == GSP_ADDR_RATE_LO;
	assign wrRateHi = regWrStrobe && regAddr == GSP_ADDR_RATE_HI;
	assign wrTempLo = regWrStrobe && regAddr == GSP_ADDR_TEMP_LO;
	assign wrTempHi = regWrStrobe && regAddr == GSP_ADDR_TEMP_HI;

	// Subcommand decode, one cycle after the high byte lands
	wire logic isOtgOn;
	wire logic isOtgOff;
	wire logic isHalfOn;
	wire logic isHalfOff;
	wire logic isProfZero;
	wire logic isProfOne;
	wire logic isChgRelease;
	wire logic isChgBlock;
	wire logic isHostGrant;
	wire logic isHostRevoke;
	wire logic isCfgRev;
	wire logic isSeal;
	wire logic isGaugeStart;
	wire logic isFullReset;
	wire logic isShipOn;
	wire logic isShipOff;
	assign isOtgOn = execute_q && cmdWord_q == GSP_CMD_OTG_ON;
	assign isOtgOff = execute_q && cmdWord_q == GSP_CMD_OTG_OFF;
	assign isHalfOn = execute_q && cmdWord_q == GSP_CMD_HALF_ON;
	assign isHalfOff = execute_q && cmdWord_q == GSP_CMD_HALF_OFF;
	assign isProfZero = execute_q && cmdWord_q == GSP_CMD_PROF_ZERO;
	assign isProfOne = execute_q && cmdWord_q == GSP_CMD_PROF_ONE;
	assign isChgRelease = execute_q && cmdWord_q == GSP_CMD_CHG_RELEASE;
	assign isChgBlock = execute_q && cmdWord_q == GSP_CMD_CHG_BLOCK;
	assign isHostGrant = execute_q && cmdWord_q == GSP_CMD_HOST_GRANT && !cmdNotRequired;
	assign isHostRevoke = execute_q && cmdWord_q == GSP_CMD_HOST_REVOKE && !cmdNotRequired;
	assign isCfgRev = execute_q && cmdWord_q == GSP_CMD_CFG_REV;
	assign isSeal = execute_q && cmdWord_q == GSP_CMD_SEAL;
	// Sealed refusals simply match nothing
	assign isGaugeStart = execute_q && cmdWord_q == GSP_CMD_GAUGE_START && !sealed_q;
	assign isFullReset = execute_q && cmdWord_q == GSP_CMD_FULL_RESET && !sealed_q;
	assign isShipOn = execute_q && cmdWord_q == GSP_CMD_SHIP_ON;
	assign isShipOff = execute_q && cmdWord_q == GSP_CMD_SHIP_OFF;

	// One-second enable for forecast refresh and ship delay
	wire logic tickWrap;
	assign tickWrap = tickCount_q == 32'(REFRESH_CYCLES - 1);

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tickCount_q <= 32'h0;
			tick_q <= 1'b0;
		end else begin
			tickCount_q <= tickWrap ? 32'h0 : 32'(tickCount_q + 32'h1);
			tick_q <= tickWrap;
		end
	end

	// Forecast calculator
	gsp_fct_if fct ();
	logic pendingCalc_q;
	assign fct.rate = rate_q;
	assign fct.capacity = sCapacity;
	// A write or tick during a running division is held, not lost
	assign fct.start = pendingCalc_q && !fct.busy;

	gsp_forecast_calc u_calc (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.fct(fct)
	);

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pendingCalc_q <= 1'b0;
		end else if (rateCommit_q || tick_q) begin
			pendingCalc_q <= 1'b1;
		end else if (fct.start) begin
			pendingCalc_q <= 1'b0;
		end
	end

	// Host-facing words
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cmdWord_q <= 16'h0;
			execute_q <= 1'b0;
			rateLo_q <= 8'h0;
			rate_q <= GSP_RATE_RESET;
			rateCommit_q <= 1'b0;
			tempLo_q <= 8'h0;
			temp_q <= GSP_TEMP_RESET;
		end else if (fullReset_q) begin
			cmdWord_q <= 16'h0;
			execute_q <= 1'b0;
			rateLo_q <= 8'h0;
			rate_q <= GSP_RATE_RESET;
			rateCommit_q <= 1'b0;
			tempLo_q <= 8'h0;
			temp_q <= GSP_TEMP_RESET;
		end else begin
			execute_q <= wrCmdHi;
			rateCommit_q <= wrRateHi;
			if (wrCmdLo) begin
				cmdWord_q[7:0] <= regWrData;
			end else if (isCfgRev) begin
				cmdWord_q <= configRevision;
			end
			if (wrCmdHi) begin
				cmdWord_q[15:8] <= regWrData;
			end
			// Low byte is staged so the word changes atomically
			if (wrRateLo) begin
				rateLo_q <= regWrData;
			end
			if (wrRateHi) begin
				rate_q <= {regWrData, rateLo_q};
			end
			if (wrTempLo) begin
				tempLo_q <= regWrData;
			end
			if (wrTempHi && writeTemperatureOption) begin
				temp_q <= {regWrData, tempLo_q};
			end
		end
	end

	// Charger and gauge control state
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			otg_q <= 1'b0;
			blockChg_q <= 1'b0;
			half_q <= 1'b0;
			host_q <= 1'b0;
			prof_q <= 1'b0;
			removal_q <= 1'b0;
			gstart_q <= 1'b0;
			genable_q <= 8'h0;
			vok_q <= 1'b0;
			qen_q <= 1'b0;
			sealed_q <= 1'b0;
			fullReset_q <= 1'b0;
		end else if (fullReset_q) begin
			otg_q <= 1'b0;
			blockChg_q <= 1'b0;
			half_q <= 1'b0;
			host_q <= 1'b0;
			prof_q <= 1'b0;
			removal_q <= 1'b0;
			gstart_q <= 1'b0;
			genable_q <= 8'h0;
			vok_q <= 1'b0;
			qen_q <= 1'b0;
			sealed_q <= 1'b0;
			fullReset_q <= 1'b0;
		end else begin
			if (isOtgOn) begin
				otg_q <= 1'b1;
			end else if (isOtgOff) begin
				otg_q <= 1'b0;
			end
			if (isHalfOn) begin
				half_q <= 1'b1;
			end else if (isHalfOff) begin
				half_q <= 1'b0;
			end
			if (isChgBlock) begin
				blockChg_q <= 1'b1;
			end else if (isChgRelease) begin
				blockChg_q <= 1'b0;
			end
			if (isHostGrant) begin
				host_q <= 1'b1;
			end else if (isHostRevoke) begin
				host_q <= 1'b0;
			end
			if (isProfZero) begin
				prof_q <= 1'b0;
			end else if (isProfOne) begin
				prof_q <= 1'b1;
			end
			// Removal only on an actual profile change
			removal_q <= (isProfZero && prof_q) || (isProfOne && !prof_q);
			if (isSeal) begin
				sealed_q <= 1'b1;
			end
			gstart_q <= isGaugeStart;
			if (isGaugeStart) begin
				genable_q <= GSP_GAUGE_ENABLE_VAL;
				qen_q <= 1'b1;
				vok_q <= 1'b1;
			end else if (sVoltsBad) begin
				vok_q <= 1'b0;
			end
			fullReset_q <= isFullReset;
		end
	end

	// Ship mode delay, counted in one-second ticks
	wire logic shipExpire;
	assign shipExpire = shipPending_q && tick_q && shipCount_q == '0;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			shipPending_q <= 1'b0;
			switchOn_q <= 1'b1;
			shipCount_q <= '0;
		end else if (fullReset_q) begin
			shipPending_q <= 1'b0;
			switchOn_q <= 1'b1;
			shipCount_q <= '0;
		end else if (isShipOn) begin
			shipPending_q <= 1'b1;
			shipCount_q <= shipDelaySeconds;
		end else if (isShipOff) begin
			shipPending_q <= 1'b0;
			if (!switchOn_q && sVbus) begin
				switchOn_q <= 1'b1;
			end
		end else if (shipExpire) begin
			shipPending_q <= 1'b0;
			switchOn_q <= 1'b0;
		end else if (shipPending_q && tick_q) begin
			shipCount_q <= DELAY_W'(shipCount_q - 1'b1);
		end
	end

	// Read-side words
	wire logic [15:0] tempRead;
	wire logic [15:0] voltRead;
	logic [15:0] flagWord;
	wire logic [7:0] rdMux;
	wire logic chargingNow;

	assign tempRead = writeTemperatureOption ? temp_q :
		(sensorSelectOption ? sExtTemp : sIntTemp);
	assign voltRead = (sVoltage > GSP_VOLT_MAX_MV) ? GSP_VOLT_MAX_MV : sVoltage;
	assign chargingNow = !chargeEnableN;

	// Status word assembly
	always_comb begin
		flagWord = 16'h0;
		flagWord[GSP_FLAG_OVER_TEMP] = sOverTemp;
		flagWord[GSP_FLAG_UNDER_TEMP] = sUnderTemp;
		flagWord[GSP_FLAG_CALIB] = sCalib;
		flagWord[GSP_FLAG_HALF_CUR] = half_q;
		flagWord[GSP_FLAG_HOST_CTRL] = host_q;
		flagWord[GSP_FLAG_FULL_CHG] = sFullChg;
		flagWord[GSP_FLAG_CHARGING] = chargingNow;
		flagWord[GSP_FLAG_GOOD_OCV] = sGoodOcv;
		flagWord[GSP_FLAG_AWAIT_ID] = sAwaitId;
		flagWord[GSP_FLAG_BATT_DET] = sBattDet;
		flagWord[GSP_FLAG_SOC_ONE] = sSocOne;
		flagWord[GSP_FLAG_SYS_DOWN] = sSysDown;
		flagWord[GSP_FLAG_DISCHG] = sDischg;
	end

	// Unmapped addresses read as zero
	assign rdMux =
		(regAddr == GSP_ADDR_CMD_LO) ? cmdWord_q[7:0] :
		(regAddr == GSP_ADDR_CMD_HI) ? cmdWord_q[15:8] :
		(regAddr == GSP_ADDR_RATE_LO) ? rate_q[7:0] :
		(regAddr == GSP_ADDR_RATE_HI) ? rate_q[15:8] :
		(regAddr == GSP_ADDR_TTE_LO) ? fct.timeToEmpty[7:0] :
		(regAddr == GSP_ADDR_TTE_HI) ? fct.timeToEmpty[15:8] :
		(regAddr == GSP_ADDR_TEMP_LO) ? tempRead[7:0] :
		(regAddr == GSP_ADDR_TEMP_HI) ? tempRead[15:8] :
		(regAddr == GSP_ADDR_VOLT_LO) ? voltRead[7:0] :
		(regAddr == GSP_ADDR_VOLT_HI) ? voltRead[15:8] :
		(regAddr == GSP_ADDR_FLAG_LO) ? flagWord[7:0] :
		(regAddr == GSP_ADDR_FLAG_HI) ? flagWord[15:8] : 8'h00;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rdData_q <= 8'h0;
		end else begin
			rdData_q <= regRdStrobe ? rdMux : 8'h0;
		end
	end

	// Outputs
	assign regRdData = rdData_q;
	assign otgEnable = otg_q;
	assign chargeEnableN = blockChg_q | sAlgoCeN;
	assign halfCurrent = half_q;
	assign hostControl = host_q;
	assign batteryPowerSwitchOn = switchOn_q;
	assign packProfileSelect = prof_q;
	assign packRemovalPulse = removal_q;
	assign gaugingStartPulse = gstart_q;
	assign gaugingEnable = genable_q;
	assign voltageOkFlag = vok_q;
	assign capacityUpdateEnable = qen_q;
	assign sealed = sealed_q;
	assign fullResetPulse = fullReset_q;
endmodule

// ### testbench/gsp_port_sva.sv
// Assertion checker for the subcommand and status port
`timescale 1ns/1ps
module gsp_port_sva (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrStrobe,
	input wire logic regRdStrobe,
	input wire logic [7:0] regRdData,
	// Configuration and control outputs
	input wire logic cmdNotRequired,
	input wire logic otgEnable,
	input wire logic chargeEnableN,
	input wire logic halfCurrent,
	input wire logic hostControl,
	input wire logic packProfileSelect,
	input wire logic packRemovalPulse,
	input wire logic gaugingStartPulse,
	input wire logic sealed
);
	logic [7:0] cmdLo_q;
	// Low byte staged so the whole code is known at the high-byte write
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			cmdLo_q <= 8'h00;
		else if (regWrStrobe && regAddr == 8'h00)
			cmdLo_q <= regWrData;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	sequence s_cmd(logic [15:0] c);
		regWrStrobe && regAddr == 8'h01 && {regWrData, cmdLo_q} == c;
	endsequence
	property p_otg_on; s_cmd(16'h0015) |-> ##2 otgEnable; endproperty
	property p_otg_off; s_cmd(16'h0016) |-> ##2 !otgEnable; endproperty
	property p_half_on; s_cmd(16'h0017) |-> ##2 halfCurrent; endproperty
	property p_half_off; s_cmd(16'h001e) |-> ##2 !halfCurrent; endproperty
	property p_prof_a;
		s_cmd(16'h0018) ##0 packProfileSelect |-> ##2 !packProfileSelect && packRemovalPulse;
	endproperty
	property p_prof_b;
		s_cmd(16'h0019) ##0 !packProfileSelect |-> ##2 packProfileSelect && packRemovalPulse;
	endproperty
	property p_block; s_cmd(16'h001b) |-> ##2 chargeEnableN [*3]; endproperty
	property p_grant;
		s_cmd(16'h001c) |-> ##2 hostControl == ($past(hostControl, 2) || !$past(cmdNotRequired, 2));
	endproperty
	property p_seal; s_cmd(16'h0020) |-> ##2 sealed [*4]; endproperty
	property p_gstart; s_cmd(16'h0021) |-> ##2 gaugingStartPulse != $past(sealed, 2); endproperty
	property p_rd_idle; !regRdStrobe |=> regRdData == 8'h00; endproperty
	a_otg_on: assert property (p_otg_on) else $error("otg not enabled");
	a_otg_off: assert property (p_otg_off) else $error("otg not disabled");
	a_half_on: assert property (p_half_on) else $error("half current not set");
	a_half_off: assert property (p_half_off) else $error("half current not cleared");
	a_prof_a: assert property (p_prof_a) else $error("profile zero wrong");
	a_prof_b: assert property (p_prof_b) else $error("profile one wrong");
	a_block: assert property (p_block) else $error("charge not blocked");
	a_grant: assert property (p_grant) else $error("host grant wrong");
	a_seal: assert property (p_seal) else $error("seal not held");
	a_gstart: assert property (p_gstart) else $error("gauge start wrong");
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
endmodule
bind gsp_port gsp_port_sva u_sva (.*);

// ### testbench/gsp_host_model.sv
// Host model driving the byte register port
`timescale 1ns/1ps
module gsp_host_model (
	// Clock
	input wire logic ref_clk,
	// Register port
	output logic [7:0] regAddr,
	output logic [7:0] regWrData,
	output logic regWrStrobe,
	output logic regRdStrobe,
	input wire logic [7:0] regRdData
);
	initial begin
		{regAddr, regWrData, regWrStrobe, regRdStrobe} = '0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWrData <= d;
		regWrStrobe <= 1'b1;
		@(posedge ref_clk);
		regWrStrobe <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regRdStrobe <= 1'b1;
		@(posedge ref_clk);
		regRdStrobe <= 1'b0;
		@(posedge ref_clk) d = regRdData;
	endtask
	// Low byte first, high byte commits the word
	task automatic wword(input logic [7:0] a, input logic [15:0] v);
		wr(a, v[7:0]);
		wr(a + 8'h01, v[15:8]);
	endtask
	task automatic rword(input logic [7:0] a, output logic [15:0] d);
		logic [7:0] lo, hi;
		rd(a, lo);
		rd(a + 8'h01, hi);
		d = {hi, lo};
	endtask
endmodule

// ### testbench/gsp_port_tb_top.sv
// Self-checking bench for the subcommand and status port
`timescale 1ns/1ps
module gsp_port_tb_top;
	logic ref_clk, resetn, cmdNotRequired, writeTemperatureOption, sensorSelectOption;
	logic vbusPresent, overTempCond, underTempCond, calibrationActive, fullCharge;
	logic goodRestVoltage, awaitingPackId, batteryDetected, chargeThresholdOne;
	logic systemShutdown, dischargingCond, voltagesUnsuitable, algoChargeEnableN;
	logic otgEnable, chargeEnableN, halfCurrent, hostControl, batteryPowerSwitchOn;
	logic packProfileSelect, packRemovalPulse, gaugingStartPulse, voltageOkFlag;
	logic capacityUpdateEnable, sealed, fullResetPulse, regWrStrobe, regRdStrobe;
	logic [7:0] regAddr, regWrData, regRdData, gaugingEnable;
	logic [15:0] configRevision, shipDelaySeconds, measuredVoltage, internalTemp;
	logic [15:0] externalTemp, remainingCapacity, w, r, v;
	logic [31:0] f;
	logic [15:0] codes [13] = '{16'h0015, 16'h0016, 16'h0017, 16'h001e, 16'h0019, 16'h0018,
		16'h0019, 16'h001b, 16'h001a, 16'h001c, 16'h001d, 16'h0021, 16'h003f};
	int mismatches = 0, cmpCount = 0, i;
	// Short refresh period keeps the run brief
	gsp_port #(.REFRESH_CYCLES(100)) dut (.*);
	gsp_host_model host (.*);
	always #2 ref_clk = ~ref_clk;
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		cmpCount++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic end_sim;
		$display("mismatches %0d compares %0d", mismatches, cmpCount);
		if (mismatches == 0 && cmpCount > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Spacing keeps command outputs apart
	task automatic cmd(input logic [15:0] c);
		host.wword(8'h00, c);
		repeat (3) @(posedge ref_clk);
	endtask
	function automatic logic [15:0] tte_exp(logic [15:0] c, logic [15:0] rt);
		logic [31:0] q;
		if (!rt[15])
			return 16'hffff;
		q = ({16'h0, c} * 32'd60) / {16'h0, 16'(-rt)};
		return (q > 32'hfffe) ? 16'hfffe : q[15:0];
	endfunction
	initial begin
		repeat (20000) @(posedge ref_clk);
		mismatches++;
		end_sim();
	end
	initial begin
		{ref_clk, resetn, cmdNotRequired, writeTemperatureOption, sensorSelectOption} = '0;
		{vbusPresent, overTempCond, underTempCond, calibrationActive, fullCharge} = '0;
		{goodRestVoltage, awaitingPackId, batteryDetected, chargeThresholdOne} = '0;
		{systemShutdown, dischargingCond, voltagesUnsuitable, algoChargeEnableN} = '0;
		{configRevision, measuredVoltage, internalTemp, externalTemp} = '0;
		remainingCapacity = 16'h0000;
		shipDelaySeconds = 16'h0002;
		f = $urandom(32'h3f0c);
		repeat (3) @(posedge ref_clk);
		resetn <= 1'b1;
		host.rword(8'h02, w); chk("rate", 16'h0000, w);
		host.rword(8'h04, w); chk("tte", 16'hffff, w);
		configRevision <= 16'($urandom);
		cmd(16'h001f);
		host.rword(8'h00, w); chk("rev", configRevision, w);
		// Forecast words used only while running normally
		for (i = 0; i < 5; i++) begin
			remainingCapacity <= 16'($urandom);
			if (i != 2) begin
				r = (i == 0) ? 16'hffff : (i == 4) ? 16'h0000 : {1'b1, 15'($urandom)};
				host.wword(8'h02, r);
			end
			repeat (160) @(posedge ref_clk);
			host.rword(8'h02, w); chk("rate", r, w);
			host.rword(8'h04, w); chk("tte", tte_exp(remainingCapacity, r), w);
		end
		for (i = 0; i < 3; i++) begin
			v = (i == 0) ? 16'h1771 : (i == 1) ? 16'h1770 : 16'($urandom % 6000);
			measuredVoltage <= v;
			host.wword(8'h08, 16'h0bad);
			host.rword(8'h08, w); chk("volt", (v > 16'h1770) ? 16'h1770 : v, w);
		end
		writeTemperatureOption <= 1'b1;
		v = 16'($urandom);
		host.wword(8'h06, v);
		host.rword(8'h06, w); chk("temp", v, w);
		writeTemperatureOption <= 1'b0;
		internalTemp <= ~v;
		repeat (4) @(posedge ref_clk);
		host.rword(8'h06, w); chk("temp", ~v, w);
		repeat (4) begin
			f = $urandom;
			{overTempCond, underTempCond, calibrationActive, fullCharge, goodRestVoltage,
				awaitingPackId, batteryDetected, chargeThresholdOne, systemShutdown,
				dischargingCond, algoChargeEnableN} <= f[10:0];
			repeat (4) @(posedge ref_clk);
			host.rword(8'h0a, w);
			chk("flags", {f[10:9], 1'b0, f[8], 2'b00, f[7], !f[0], 2'b00, f[6:1]}, w);
		end
		algoChargeEnableN <= 1'b0;
		foreach (codes[j]) begin
			cmdNotRequired <= 1'($urandom);
			cmd(codes[j]);
		end
		chk("chargeN", 16'h0000, chargeEnableN);
		chk("gauge", 16'h0301, {voltageOkFlag, capacityUpdateEnable, gaugingEnable});
		host.wword(8'h02, 16'h8001);
		cmd(16'h0041);
		host.rword(8'h02, w); chk("rate", 16'h0000, w);
		cmd(16'h0050);
		for (i = 0; i < 400 && batteryPowerSwitchOn; i++) @(posedge ref_clk);
		chk("switch", 16'h0000, batteryPowerSwitchOn);
		if (i == 400)
			end_sim();
		vbusPresent <= 1'b1;
		cmd(16'h0051);
		chk("switch", 16'h0001, batteryPowerSwitchOn);
		cmd(16'h0020);
		cmd(16'h0021);
		cmd(16'h0041);
		chk("sealed", 16'h0001, sealed);
		end_sim();
	end
endmodule
